//--- sfr_flash.sv
`timescale 1ns/1ns
module sfr_flash #(
	parameter int REGW_CYC = sfr_pkg::REGW_CYC_DEF,
	parameter int PROG_CYC = sfr_pkg::PROG_CYC_DEF,
	parameter int MEM_AW = sfr_pkg::MEM_AW_DEF
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic si,
	input wire logic write_protect_pin,
	output logic so,
	output logic so_oe,
	output logic write_in_progress,
	output logic write_enable_latch,
	output logic [2:0] block_guard_bits,
	output logic hardware_lock_mode,
	input wire logic [MEM_AW-1:0] arr_raddr,
	output logic [7:0] arr_rdata
);
	// busy checks below look 8 cycles ahead, so shorter register cycles are refused
	if (PROG_CYC < sfr_pkg::PAGE_BYTES || REGW_CYC < 9 || MEM_AW < 9 || MEM_AW > 24) begin : g_chk
		$error("sfr_flash: unsupported parameter values");
	end

	sfr_pkg::sfr_core_s cr, c;
	sfr_pkg::sfr_lfrm_s lk, lk_n;
	sfr_pkg::sfr_lper_s lp, lp_n;
	logic [7:0] pbuf [0:255];
	// array comes up erased; nothing in this block erases it
	logic [7:0] arr [0:(1<<MEM_AW)-1] = '{default: 8'hff};
	logic so_ff, so_oe_ff, lrst_n, lbyte_done;
	logic fstart, fend, bev, idle, aligned, bwe, regw_go, prog_go, reg_done;
	logic [7:0] bidx, arr_rdata_ff;
	logic [MEM_AW-1:0] paddr;

	// guarded region: top 1/2^(7-bp) of the array for bp 1 to 7, bp=7 guards all, bp=0 guards none
	function automatic logic guarded(input logic [MEM_AW-1:0] a, input logic [2:0] bp);
		logic [MEM_AW-1:0] lim;
		lim = ~({MEM_AW{1'b1}} >> (3'd7 - bp));
		return (bp != 3'd0) && ((a & lim) == lim);
	endfunction

	// link frame logic is cleared while deselected so each frame starts aligned
	assign lrst_n = rst_n & ~cs_n;
	assign lbyte_done = (lk.cnt == 3'd7);

	// link side: shift in MSB first, shift read data out
	always_comb begin
		lk_n = lk;
		lp_n = lp;
		lk_n.cnt = lk.cnt + 3'd1;
		lk_n.sh = {lk.sh[5:0], si};
		lp_n.part = ~lbyte_done;
		lp_n.q = {lp.q[0], cr.req};
		if (lp.q[1] != lp.ack) begin
			lp_n.word = cr.snap;
			lp_n.ack = lp.q[1];
		end
		if (lbyte_done) begin
			lp_n.byt = {lk.sh, si};
			lp_n.tgl = ~lp.tgl;
		end
		if (lbyte_done && !lk.first) begin
			lk_n.first = 1'b1;
			if ({lk.sh, si} == sfr_pkg::OP_STAT_READ) begin
				lk_n.sel = 2'd1;
				lk_n.out = lp.word[7:0];
			end else if ({lk.sh, si} == sfr_pkg::OP_CFG_READ) begin
				lk_n.sel = 2'd2; // answered even mid-cycle
				lk_n.out = lp.word[15:8];
			end
		end else if (lk.sel != 2'd0) begin
			if (lbyte_done) begin
				lk_n.out = (lk.sel == 2'd1) ? lp.word[7:0] : lp.word[15:8];
			end else begin
				lk_n.out = {lk.out[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge sclk or negedge lrst_n) begin
		if (!lrst_n) begin
			lk <= '0;
		end else begin
			lk <= lk_n;
		end
	end

	// persistent link state survives deselect so core can see partial bytes
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			lp <= '0;
		end else begin
			lp <= lp_n;
		end
	end

	// output changes on falling edge so host samples it on the rise
	always_ff @(negedge sclk or negedge lrst_n) begin
		if (!lrst_n) begin
			so_ff <= 1'b0;
			so_oe_ff <= 1'b0;
		end else begin
			so_ff <= (lk.sel != 2'd0) & lk.out[7];
			so_oe_ff <= (lk.sel != 2'd0);
		end
	end

	assign fstart = ~cr.cs_s[1] & cr.cs_s[2];
	assign fend = cr.cs_s[2] & ~cr.cs_s[3];
	assign bev = cr.tg_s[1] ^ cr.tg_s[2];
	assign idle = (cr.bk == sfr_pkg::BK_IDLE);
	assign aligned = ~cr.pt_s[1];
	assign paddr = MEM_AW'(cr.addr);

	// core side: command decode, registers, self-timed cycles
	always_comb begin
		c = cr;
		bwe = 1'b0;
		bidx = 8'h00;
		regw_go = 1'b0;
		prog_go = 1'b0;
		reg_done = 1'b0;
		c.cs_s = {cr.cs_s[2:0], cs_n};
		c.tg_s = {cr.tg_s[1:0], lp.tgl};
		c.pt_s = {cr.pt_s[0], lp.part};
		c.ak_s = {cr.ak_s[0], lp.ack};
		c.wp_s = {cr.wp_s[0], write_protect_pin};
		// lock mode: set by lock bit with pin low, left by pin high or four-lane bit set
		if (cr.wp_s[1] || cr.cfg[sfr_pkg::CFG_QUAD]) begin
			c.hlock = 1'b0;
		end else if (cr.st.lock) begin
			c.hlock = 1'b1;
		end
		// register snapshot handed to link side by req/ack
		if (cr.req == cr.ak_s[1]) begin
			c.snap = {cr.cfg, cr.st};
			c.req = ~cr.req;
		end
		if (fstart) begin
			c.fs = sfr_pkg::FS_OP;
			c.cnt = 9'h000;
		end else if (bev) begin
			case (cr.fs)
				sfr_pkg::FS_OP: begin
					c.op = lp.byt;
					if (lp.byt == sfr_pkg::OP_PAGE_PROG) begin
						c.fs = sfr_pkg::FS_ADDR;
					end else if (lp.byt == sfr_pkg::OP_REG_WRITE) begin
						c.fs = sfr_pkg::FS_DATA;
					end else begin
						c.fs = sfr_pkg::FS_SKIP;
					end
				end
				sfr_pkg::FS_ADDR: begin
					c.addr = {cr.addr[15:0], lp.byt};
					c.cnt = cr.cnt + 9'h001;
					if (cr.cnt == 9'(sfr_pkg::ADDR_BYTES - 1)) begin
						c.fs = sfr_pkg::FS_DATA;
						c.cnt = 9'h000;
						if (idle) begin
							c.vmask = '0;
						end
					end
				end
				sfr_pkg::FS_DATA: begin
					// buffer untouched while a program is running
					if (cr.op == sfr_pkg::OP_PAGE_PROG && idle) begin
						bwe = 1'b1;
						bidx = 8'(cr.addr[7:0] + cr.cnt[7:0]); // wrap in page
						c.vmask[bidx] = 1'b1; // only received bytes
					end
					c.wdat = {cr.wdat[7:0], lp.byt};
					if (cr.cnt != 9'h1ff) begin
						c.cnt = cr.cnt + 9'h001;
					end
				end
				default: begin
					if (cr.cnt != 9'h1ff) begin
						c.cnt = cr.cnt + 9'h001;
					end
				end
			endcase
		end
		// end of frame: decide what the frame asked for
		if (fend && idle && aligned) begin
			if (cr.fs == sfr_pkg::FS_SKIP && cr.cnt == 9'h000) begin
				if (cr.op == sfr_pkg::OP_WRITE_UNLOCK) begin
					c.st.unlk = 1'b1;
				end else if (cr.op == sfr_pkg::OP_WRITE_RELOCK) begin
					c.st.unlk = 1'b0;
				end
			end
			// exactly 8 or 16 data bits, latch set, not locked
			if (cr.op == sfr_pkg::OP_REG_WRITE && cr.st.unlk && !cr.hlock &&
					(cr.cnt == 9'h001 || cr.cnt == 9'h002)) begin
				regw_go = 1'b1;
				c.pcf_v = (cr.cnt == 9'h002);
				c.pst = (cr.cnt == 9'h002) ? cr.wdat[15:8] : cr.wdat[7:0];
				c.pcf = cr.wdat[7:0];
				c.bk = sfr_pkg::BK_REG;
				c.bcnt = 16'(REGW_CYC - 1);
				c.st.busy = 1'b1;
			end
			// byte-aligned, at least one data byte, page not guarded
			if (cr.op == sfr_pkg::OP_PAGE_PROG && cr.st.unlk && cr.fs == sfr_pkg::FS_DATA &&
					cr.cnt != 9'h000 && !guarded(paddr, cr.st.bp)) begin
				prog_go = 1'b1;
				c.bk = sfr_pkg::BK_PROG;
				c.bcnt = 16'(PROG_CYC - 1);
				c.st.busy = 1'b1;
				c.st.unlk = 1'b0; // cleared before completion
			end
		end
		// self-timed cycle countdown
		if (!idle) begin
			if (cr.bcnt == 16'h0000) begin
				c.bk = sfr_pkg::BK_IDLE;
				c.st.busy = 1'b0;
				c.st.unlk = 1'b0;
				if (cr.bk == sfr_pkg::BK_REG) begin
					reg_done = 1'b1;
					// error bits kept; latch and busy bits cleared above
					c.st.lock = cr.pst[7];
					c.st.bp = cr.pst[4:2];
					if (cr.pcf_v) begin
						c.cfg = cr.pcf & sfr_pkg::CFG_WMASK;
					end
				end
			end else begin
				c.bcnt = cr.bcnt - 16'h0001;
			end
		end
	end

	// register values after reset
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cr <= '0;
			cr.cs_s <= 4'hf;
			cr.wp_s <= 2'b11;
			cr.st <= sfr_pkg::REG_RST;
			cr.cfg <= sfr_pkg::REG_RST;
		end else begin
			cr <= c;
		end
	end

	// page buffer and array; programming only clears bits
	always_ff @(posedge core_clk) begin
		if (bwe) begin
			pbuf[bidx] <= lp.byt;
		end
		if (cr.bk == sfr_pkg::BK_PROG && cr.bcnt < 16'(sfr_pkg::PAGE_BYTES)
				&& cr.vmask[cr.bcnt[7:0]]) begin
			arr[{paddr[MEM_AW-1:8], cr.bcnt[7:0]}] <=
				arr[{paddr[MEM_AW-1:8], cr.bcnt[7:0]}] & pbuf[cr.bcnt[7:0]];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			arr_rdata_ff <= 8'h00;
		end else begin
			arr_rdata_ff <= arr[arr_raddr];
		end
	end

	assign so = so_ff;
	assign so_oe = so_oe_ff;
	assign write_in_progress = cr.st.busy;
	assign write_enable_latch = cr.st.unlk;
	assign block_guard_bits = cr.st.bp;
	assign hardware_lock_mode = cr.hlock;
	assign arr_rdata = arr_rdata_ff;

	AST_REGW_BUSY: assert property (@(posedge core_clk) disable iff (!rst_n)
		regw_go |=> write_in_progress [*8])
		else $error("busy flag not held after register write start");
	AST_REGW_LEN: assert property (@(posedge core_clk) disable iff (!rst_n)
		regw_go |-> aligned && (cr.cnt == 9'h001 || cr.cnt == 9'h002))
		else $error("register write taken at bad length");
	AST_REGW_LATCH: assert property (@(posedge core_clk) disable iff (!rst_n)
		reg_done |=> !write_enable_latch && !write_in_progress)
		else $error("latch or busy left set after register write");
	AST_ERR_KEEP: assert property (@(posedge core_clk) disable iff (!rst_n)
		reg_done |=> $stable(cr.st.perr) && $stable(cr.st.eerr))
		else $error("error flags changed by register write");
	AST_LOCK_REFUSE: assert property (@(posedge core_clk) disable iff (!rst_n)
		cr.hlock |-> !regw_go)
		else $error("register write taken in lock mode");
	AST_LOCK_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
		cr.hlock && !cr.wp_s[1] && !cr.cfg[sfr_pkg::CFG_QUAD] |=> cr.hlock)
		else $error("lock mode left with pin low");
	AST_QUAD_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
		cr.cfg[sfr_pkg::CFG_QUAD] |=> !cr.hlock)
		else $error("lock mode active with four-lane enabled");
	AST_RSV_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cr.cfg & ~sfr_pkg::CFG_WMASK) == 8'h00)
		else $error("reserved config bit set");
	AST_PROG_GUARD: assert property (@(posedge core_clk) disable iff (!rst_n)
		prog_go |-> !guarded(paddr, cr.st.bp) && aligned)
		else $error("program started into guarded page");
	AST_PROG_START: assert property (@(posedge core_clk) disable iff (!rst_n)
		prog_go |=> (write_in_progress && !write_enable_latch) [*8])
		else $error("program start flags wrong");
	AST_CFG_LOAD: assert property (@(posedge sclk) disable iff (!lrst_n)
		lbyte_done && !lk.first && {lk.sh, si} == sfr_pkg::OP_CFG_READ
		|=> lk.sel == 2'd2 && lk.out == $past(lp.word[15:8]))
		else $error("config read did not load config byte");
	// latch commands act only on a clean single-byte frame while idle
	AST_UNLOCK_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
		fend && idle && aligned && cr.fs == sfr_pkg::FS_SKIP && cr.cnt == 9'h000
		&& cr.op == sfr_pkg::OP_WRITE_UNLOCK |=> write_enable_latch)
		else $error("latch not set by write unlock");
	AST_RELOCK_CLR: assert property (@(posedge core_clk) disable iff (!rst_n)
		fend && idle && aligned && cr.fs == sfr_pkg::FS_SKIP && cr.cnt == 9'h000
		&& cr.op == sfr_pkg::OP_WRITE_RELOCK |=> !write_enable_latch)
		else $error("latch not cleared by write relock");
	// no new write cycle may start on top of a running one
	AST_BUSY_REFUSE: assert property (@(posedge core_clk) disable iff (!rst_n)
		!idle |-> !regw_go && !prog_go)
		else $error("write cycle started while busy");
	// deselected link never drives serial output
	AST_SO_QUIET: assert property (@(posedge core_clk) disable iff (!rst_n)
		cr.cs_s[1] && cr.cs_s[2] |-> !so_oe)
		else $error("serial output driven while deselected");

	COV_REGW1: cover property (@(posedge core_clk) disable iff (!rst_n)
		regw_go && cr.cnt == 9'h001);
	COV_REGW2: cover property (@(posedge core_clk) disable iff (!rst_n)
		regw_go && cr.cnt == 9'h002);
	COV_PROG: cover property (@(posedge core_clk) disable iff (!rst_n) prog_go);
	COV_LOCK: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(cr.hlock));
	COV_CFG_BUSY: cover property (@(posedge core_clk) disable iff (!rst_n)
		cr.st.busy && bev && cr.fs == sfr_pkg::FS_OP && lp.byt == sfr_pkg::OP_CFG_READ);
endmodule

//--- sfr_host.sv
`timescale 1ns/1ns
// host side of the serial link; sclk only runs inside a frame
module sfr_host (
	output logic sclk,
	output logic cs_n,
	output logic si,
	input wire logic so
);
	logic [7:0] txq[$];
	logic [7:0] rx;

	// idle levels before the first frame
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
		rx = 8'h00;
	end

	// msb first, change on fall, sample so on rise
	task automatic xfer(input int nbits);
		cs_n = 1'b0; // held low for the whole frame
		#32;
		for (int i = 0; i < nbits; i++) begin
			si = (i / 8 < txq.size()) ? txq[i / 8][7 - i % 8] : ~si;
			#32 sclk = 1'b1;
			rx = {rx[6:0], so};
			#32 sclk = 1'b0;
		end
		#32 cs_n = 1'b1; // rise point set by nbits
		si = ~si; // released line must not hold its last value
		txq.delete();
	endtask
endmodule

//--- sfr_pkg.sv
// What this block does
// - config read command accepted anytime, even busy; config byte shifted out on SO.
// - status and configuration registers hold 00h after reset.
// - register write acts only when write-enable latch is set.
// - register write data never writes the write-enable latch, bit 1.
// - rise after 8 data bits writes status; after 16 writes both registers.
// - any other chip-select rise point discards the register write.
// - register-write cycle starts at chip-select rise; busy flag high until done.
// - write-enable latch cleared when register-write cycle finishes.
// - register write keeps program error and erase error bits; busy is set for the cycle and cleared at its end.
// - reserved register bits always read 0.
// - protect pin high or lock bit 0: lock, guard bits, config writable.
// - lock bit 1 with protect pin low: lock mode ignores register writes.
// - lock mode entered on whichever condition comes last; left on pin high or four-lane enable set.
// - four-lane enable bit set disables lock mode.
// - page program needs write-enable, opcode, three address bytes, data.
// - programming only clears bits; unsent bytes keep their contents.
// - data past page end wraps to offset zero of the same page.
// - 257 to 512 data bytes: only the last 256 are programmed.
// - short bursts program only received bytes at their own addresses.
// - chip select must rise on a data byte boundary or program is dropped.
// - programming starts at chip-select rise; busy until done; latch cleared first.
// - page program into a guarded region is refused.
// - write-enable sets latch; write-disable and reset clear it.
// - refused program into guarded area sets no error flag.
package sfr_pkg;
	localparam logic [7:0] OP_REG_WRITE = 8'h01;
	localparam logic [7:0] OP_PAGE_PROG = 8'h02;
	localparam logic [7:0] OP_WRITE_RELOCK = 8'h04;
	localparam logic [7:0] OP_STAT_READ = 8'h05;
	localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
	localparam logic [7:0] OP_CFG_READ = 8'h35;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [7:0] CFG_WMASK = 8'h3e;
	localparam int CFG_QUAD = 1;
	localparam int PAGE_BYTES = 256;
	localparam int ADDR_BYTES = 3;
	localparam int REGW_CYC_DEF = 100;
	localparam int PROG_CYC_DEF = 400;
	localparam int MEM_AW_DEF = 16;

	typedef struct packed {
		logic lock;
		logic perr;
		logic eerr;
		logic [2:0] bp;
		logic unlk;
		logic busy;
	} sfr_stat_s;

	typedef enum logic [1:0] {FS_OP, FS_ADDR, FS_DATA, FS_SKIP} sfr_fs_e;
	typedef enum logic [1:0] {BK_IDLE, BK_REG, BK_PROG} sfr_bk_e;

	typedef struct packed {
		logic [3:0] cs_s;
		logic [2:0] tg_s;
		logic [1:0] pt_s;
		logic [1:0] ak_s;
		logic [1:0] wp_s;
		logic req;
		logic [15:0] snap;
		sfr_fs_e fs;
		logic [7:0] op;
		logic [8:0] cnt;
		logic [23:0] addr;
		logic [15:0] wdat;
		sfr_stat_s st;
		logic [7:0] cfg;
		logic hlock;
		sfr_bk_e bk;
		logic [15:0] bcnt;
		logic [7:0] pst;
		logic [7:0] pcf;
		logic pcf_v;
		logic [255:0] vmask;
	} sfr_core_s;

	typedef struct packed {
		logic [2:0] cnt;
		logic [6:0] sh;
		logic first;
		logic [1:0] sel;
		logic [7:0] out;
	} sfr_lfrm_s;

	typedef struct packed {
		logic tgl;
		logic [7:0] byt;
		logic part;
		logic [1:0] q;
		logic ack;
		logic [15:0] word;
	} sfr_lper_s;
endpackage

//--- tb_top.sv
`timescale 1ns/1ns
module tb_top;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic wpp = 1'b1;
	logic [15:0] raddr = 16'h0000;
	logic sclk, cs_n, si, so, oe, busy, latch, hlm;
	logic [2:0] bp;
	logic [7:0] rdata;
	int n_errors = 0;
	int checked = 0;

	always #5 core_clk = ~core_clk;

	sfr_host i_sfr_host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so));
	// long busy cycles so reads can overlap them
	sfr_flash #(.REGW_CYC(300), .PROG_CYC(300), .MEM_AW(16)) i_sfr_flash (
		.core_clk(core_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .si(si),
		.write_protect_pin(wpp), .so(so), .so_oe(oe), .write_in_progress(busy),
		.write_enable_latch(latch), .block_guard_bits(bp), .hardware_lock_mode(hlm),
		.arr_raddr(raddr), .arr_rdata(rdata));

	task automatic chk(input string w, input logic [7:0] got, input logic [7:0] e);
		checked++;
		if (got !== e) begin
			n_errors++;
			$display("FAIL %s exp %h got %h", w, e, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	// odd start offset keeps sclk out of phase with core_clk
	task automatic frm(input int nbits);
		cyc(1);
		#3;
		i_sfr_host.xfer(nbits);
		cyc(8);
	endtask
	task automatic op1(input logic [7:0] op);
		i_sfr_host.txq = '{op};
		frm(8);
	endtask
	task automatic regw(input logic [15:0] d, input int nb);
		i_sfr_host.txq = '{sfr_pkg::OP_REG_WRITE, d[15:8], d[7:0]};
		frm(8 + nb);
	endtask
	task automatic prog(input logic [23:0] a, input int nb);
		i_sfr_host.txq = {sfr_pkg::OP_PAGE_PROG, a[23:16], a[15:8], a[7:0], i_sfr_host.txq};
		frm(32 + nb);
	endtask
	// second copy of the byte is fresher than the first
	task automatic rd(input logic [7:0] op, input logic [7:0] e);
		i_sfr_host.txq = '{op};
		frm(24);
		chk(op == sfr_pkg::OP_CFG_READ ? "cfg" : "stat", i_sfr_host.rx, e);
		chk("so_oe", {7'h00, oe}, 8'h00);
	endtask
	// host polls busy before the next write
	task automatic idle;
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 1000) begin
			cyc(1);
			n++;
		end
		chk("busy end", {7'h00, busy}, 8'h00);
	endtask
	task automatic mem(input logic [15:0] a, input logic [7:0] e);
		raddr = a;
		cyc(2);
		chk("arr", rdata, e);
	endtask

	task automatic t_reset;
		rd(sfr_pkg::OP_STAT_READ, 8'h00);
		rd(sfr_pkg::OP_CFG_READ, 8'h00);
		regw(16'h9c3e, 16);
		chk("busy", {7'h00, busy}, 8'h00);
		rd(sfr_pkg::OP_STAT_READ, 8'h00);
		op1(sfr_pkg::OP_WRITE_UNLOCK);
		chk("latch", {7'h00, latch}, 8'h01);
		op1(sfr_pkg::OP_WRITE_RELOCK);
		chk("latch", {7'h00, latch}, 8'h00);
	endtask

	task automatic t_regw;
		op1(sfr_pkg::OP_WRITE_UNLOCK);
		regw(16'hffff, 16);
		chk("busy", {7'h00, busy}, 8'h01);
		rd(sfr_pkg::OP_CFG_READ, 8'h00);
		chk("busy", {7'h00, busy}, 8'h01);
		idle;
		rd(sfr_pkg::OP_STAT_READ, 8'h9c);
		rd(sfr_pkg::OP_CFG_READ, 8'h3e);
		op1(sfr_pkg::OP_WRITE_UNLOCK);
		regw(16'h0000, 8);
		idle;
		rd(sfr_pkg::OP_STAT_READ, 8'h00);
		rd(sfr_pkg::OP_CFG_READ, 8'h3e);
		op1(sfr_pkg::OP_WRITE_UNLOCK);
		regw(16'h0000, 12);
		chk("busy", {7'h00, busy}, 8'h00);
		rd(sfr_pkg::OP_CFG_READ, 8'h3e);
		regw(16'h0000, 16);
		idle;
		rd(sfr_pkg::OP_CFG_READ, 8'h00);
	endtask

	task automatic t_lock;
		wpp = 1'b0;
		op1(sfr_pkg::OP_WRITE_UNLOCK);
		regw(16'h8000, 8);
		idle;
		cyc(4);
		chk("lock", {7'h00, hlm}, 8'h01);
		op1(sfr_pkg::OP_WRITE_UNLOCK);
		regw(16'h0000, 8);
		rd(sfr_pkg::OP_STAT_READ, 8'h82);
		wpp = 1'b1;
		cyc(6);
		chk("lock", {7'h00, hlm}, 8'h00);
		wpp = 1'b0;
		cyc(6);
		chk("lock", {7'h00, hlm}, 8'h01);
		wpp = 1'b1;
		regw(16'h8002, 16);
		idle;
		wpp = 1'b0;
		cyc(6);
		chk("lock", {7'h00, hlm}, 8'h00);
		op1(sfr_pkg::OP_WRITE_UNLOCK);
		regw(16'h0000, 16);
		idle;
		rd(sfr_pkg::OP_STAT_READ, 8'h00);
		wpp = 1'b1;
	endtask

	task automatic t_prog;
		op1(sfr_pkg::OP_WRITE_UNLOCK);
		i_sfr_host.txq = '{8'h0f, 8'hf0, 8'h3c};
		prog(24'h0001fe, 24);
		chk("busy", {7'h00, busy}, 8'h01);
		chk("latch", {7'h00, latch}, 8'h00);
		idle;
		mem(16'h01fe, 8'h0f);
		mem(16'h01ff, 8'hf0);
		mem(16'h0100, 8'h3c);
		op1(sfr_pkg::OP_WRITE_UNLOCK);
		i_sfr_host.txq = '{8'hf5};
		prog(24'h0001fe, 8);
		idle;
		mem(16'h01fe, 8'h05);
		op1(sfr_pkg::OP_WRITE_UNLOCK);
		i_sfr_host.txq = '{8'haa};
		prog(24'h000300, 4);
		chk("busy", {7'h00, busy}, 8'h00);
		chk("latch", {7'h00, latch}, 8'h01);
		for (int k = 0; k < 258; k++) begin
			i_sfr_host.txq.push_back(k == 256 ? 8'h11 : k == 257 ? 8'h22 : 8'(k));
		end
		prog(24'h000200, 258 * 8);
		idle;
		mem(16'h0200, 8'h11);
		mem(16'h0201, 8'h22);
		mem(16'h0202, 8'h02);
		mem(16'h02ff, 8'hff);
	endtask

	task automatic t_guard;
		op1(sfr_pkg::OP_WRITE_UNLOCK);
		regw(16'h1c00, 8);
		idle;
		chk("guard", {5'h00, bp}, 8'h07);
		op1(sfr_pkg::OP_WRITE_UNLOCK);
		i_sfr_host.txq = '{8'h55};
		prog(24'h000400, 8);
		chk("busy", {7'h00, busy}, 8'h00);
		rd(sfr_pkg::OP_STAT_READ, 8'h1e);
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		cyc(12);
		rst_n = 1'b1;
		cyc(4);
		t_reset;
		$display("test reset done");
		t_regw;
		$display("test register write done");
		t_lock;
		$display("test lock done");
		t_prog;
		$display("test page program done");
		t_guard;
		$display("test guard done");
		final_report;
	end

	// watchdog, several times the expected run
	initial begin
		#2000000;
		n_errors++;
		final_report;
	end
endmodule
